// ===== inc/padmux_pkg.sv
// Constants, register map and field layout for the pad router and general I/O port
//*****************************************************************************
// Summary of operation
//*****************************************************************************
package padmux_pkg;
	localparam int NPAD = 11;
	localparam int NMAP = 19;
	localparam int SELW = 5;
	localparam int NIRQ = 18;
	localparam int DBW = 4;
	// Register byte addresses, one 32-bit word apart except the jump from A_KEYAN to A_SEL0
	localparam logic [7:0] A_DIR = 8'h00;
	localparam logic [7:0] A_OUT = 8'h04;
	localparam logic [7:0] A_IN = 8'h08;
	localparam logic [7:0] A_PU = 8'h0C;
	localparam logic [7:0] A_PD = 8'h10;
	localparam logic [7:0] A_DBEN = 8'h14;
	localparam logic [7:0] A_WKEN = 8'h18;
	localparam logic [7:0] A_IRQST = 8'h1C;
	localparam logic [7:0] A_IRQMSK = 8'h20;
	localparam logic [7:0] A_IRQPOL = 8'h24;
	localparam logic [7:0] A_FUNC = 8'h28;
	localparam logic [7:0] A_KEYAN = 8'h2C;
	localparam logic [7:0] A_SEL0 = 8'h40;
	// Function enable bits
	localparam int F_DBG = 0;
	localparam int F_GPIO = 1;
	localparam int F_KEY = 2;
	localparam int F_ANA = 3;
	localparam logic [3:0] FUNC_RST = 4'h2;
	localparam logic [NPAD-1:0] DIR_RST = 11'h000;
	localparam logic [SELW-1:0] SEL_NONE = 5'h1F;
	localparam logic [DBW-1:0] DB_CNT = 4'hF;
	// Fixed key-scan pad map: 1 = matrix input, index into key vector
	localparam logic [NPAD-1:0] KEY_IS_IN = 11'h32B;
	localparam logic [4:0] KEY_IDX [NPAD] = '{5'h08, 5'h01, 5'h01, 5'h0A, 5'h04, 5'h04,
		5'h0B, 5'h02, 5'h02, 5'h05, 5'h05};
	localparam logic [NPAD-1:0] ANA_PAD = 11'h7C0;
	localparam logic [3:0] ANA_IDX [NPAD] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
		4'h0, 4'h3, 4'h4, 4'h7, 4'h9};
endpackage

// ===== rtl/padmux_top.sv
// Pad router and general I/O port for eleven pads
`timescale 1ns/1ps
module padmux_top (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [padmux_pkg::NPAD-1:0] pad_in_i,
	output logic [padmux_pkg::NPAD-1:0] pad_out_o,
	output logic [padmux_pkg::NPAD-1:0] pad_oe_b_o,
	output logic [padmux_pkg::NPAD-1:0] pad_pu_o,
	output logic [padmux_pkg::NPAD-1:0] pad_pd_o,
	output logic [padmux_pkg::NPAD-1:0] pad_ana_o,
	input wire logic [padmux_pkg::NMAP-1:0] per_out_i,
	input wire logic [padmux_pkg::NMAP-1:0] per_oe_i,
	output logic [padmux_pkg::NMAP-1:0] per_in_o,
	input wire logic [17:0] matrix_key_output_i,
	output logic [17:0] matrix_key_input_o,
	input wire logic [padmux_pkg::NPAD-1:0] dbg_out_i,
	input wire logic [padmux_pkg::NPAD-1:0] dbg_oe_i,
	output logic wake_o,
	output logic irq_o
);
	import padmux_pkg::*;
	//*************************************************************************
	// Registers
	//*************************************************************************
	logic [NPAD-1:0] dir_q, dir_d, out_q, out_d, pu_q, pu_d, pd_q, pd_d;
	logic [NPAD-1:0] dben_q, dben_d, wken_q, wken_d, pol_q, pol_d;
	logic [NIRQ-1:0] st_q, st_d, msk_q, msk_d;
	logic [3:0] func_q, func_d;
	logic [SELW-1:0] sel_q [NPAD];
	logic [SELW-1:0] sel_d [NPAD];
	logic [31:0] rdata_d;
	logic [NPAD-1:0] filt_q, filt_d, prev_q, prev_d;
	logic [DBW-1:0] cnt_q [NPAD];
	logic [DBW-1:0] cnt_d [NPAD];
	logic [NPAD-1:0] po_d, poeb_d, ppu_d, ppd_d, pana_d;
	logic [NMAP-1:0] pin_d;
	logic [17:0] kin_d;
	logic wake_d, irq_d;
	logic [NIRQ-1:0] ev;
	logic [NPAD-1:0] sync_in;

	//*************************************************************************
	// Debounce and register next state
	//*************************************************************************
	always_comb begin
		dir_d = dir_q;
		out_d = out_q;
		pu_d = pu_q;
		pd_d = pd_q;
		dben_d = dben_q;
		wken_d = wken_q;
		pol_d = pol_q;
		msk_d = msk_q;
		func_d = func_q;
		sel_d = sel_q;
		cnt_d = cnt_q;
		filt_d = filt_q;
		prev_d = filt_q;
		sync_in = pad_in_i;
		for (int i = 0; i < NPAD; i++) begin
			// Counter filter trades latency for glitch immunity
			if (!dben_q[i]) begin
				filt_d[i] = sync_in[i];
				cnt_d[i] = '0;
			end else if (sync_in[i] == filt_q[i]) begin
				cnt_d[i] = '0;
			end else if (cnt_q[i] == DB_CNT) begin
				filt_d[i] = sync_in[i];
				cnt_d[i] = '0;
			end else begin
				cnt_d[i] = cnt_q[i] + 4'h1;
			end
		end
		ev = '0;
		for (int i = 0; i < NPAD; i++) begin
			ev[i] = (filt_q[i] != prev_q[i]) && (filt_q[i] == pol_q[i]);
		end
		st_d = st_q;
		if (wr_i) begin
			unique case (addr_i)
				A_DIR: dir_d = wdata_i[NPAD-1:0];
				A_OUT: out_d = wdata_i[NPAD-1:0];
				A_PU: pu_d = wdata_i[NPAD-1:0];
				A_PD: pd_d = wdata_i[NPAD-1:0];
				A_DBEN: dben_d = wdata_i[NPAD-1:0];
				A_WKEN: wken_d = wdata_i[NPAD-1:0];
				A_IRQST: st_d = st_q & ~wdata_i[NIRQ-1:0];
				A_IRQMSK: msk_d = wdata_i[NIRQ-1:0];
				A_IRQPOL: pol_d = wdata_i[NPAD-1:0];
				A_FUNC: func_d = wdata_i[3:0];
				default: begin
					for (int i = 0; i < NPAD; i++) begin
						if (addr_i == A_SEL0 + 8'(4 * i)) begin
							sel_d[i] = wdata_i[SELW-1:0];
						end
					end
				end
			endcase
		end
		// Set wins over a same-cycle clear
		st_d = st_d | ev;
		rdata_d = '0;
		if (rd_i) begin
			unique case (addr_i)
				A_DIR: rdata_d[NPAD-1:0] = dir_q;
				A_OUT: rdata_d[NPAD-1:0] = out_q;
				A_IN: rdata_d[NPAD-1:0] = filt_q;
				A_PU: rdata_d[NPAD-1:0] = pu_q;
				A_PD: rdata_d[NPAD-1:0] = pd_q;
				A_DBEN: rdata_d[NPAD-1:0] = dben_q;
				A_WKEN: rdata_d[NPAD-1:0] = wken_q;
				A_IRQST: rdata_d[NIRQ-1:0] = st_q;
				A_IRQMSK: rdata_d[NIRQ-1:0] = msk_q;
				A_IRQPOL: rdata_d[NPAD-1:0] = pol_q;
				A_FUNC: rdata_d[3:0] = func_q;
				default: begin
					for (int i = 0; i < NPAD; i++) begin
						if (addr_i == A_SEL0 + 8'(4 * i)) begin
							rdata_d[SELW-1:0] = sel_q[i];
						end
					end
				end
			endcase
		end
	end

	//*************************************************************************
	// Pad routing
	//*************************************************************************
	always_comb begin
		po_d = '0;
		poeb_d = '1;
		pana_d = '0;
		pin_d = '0;
		kin_d = '0;
		ppu_d = pu_q;
		ppd_d = pd_q;
		for (int i = 0; i < NPAD; i++) begin
			// Fixed functions checked first so they override the mux
			if (func_q[F_DBG]) begin
				po_d[i] = dbg_out_i[i];
				poeb_d[i] = ~dbg_oe_i[i];
			end else if (func_q[F_ANA] && ANA_PAD[i]) begin
				pana_d[i] = 1'b1;
			end else if (func_q[F_KEY]) begin
				if (KEY_IS_IN[i]) begin
					kin_d[KEY_IDX[i]] = filt_q[i];
				end else begin
					po_d[i] = matrix_key_output_i[KEY_IDX[i]];
					poeb_d[i] = 1'b0;
				end
			end else if (func_q[F_GPIO]) begin
				po_d[i] = out_q[i];
				poeb_d[i] = ~dir_q[i];
			end else if (sel_q[i] < SELW'(NMAP)) begin
				po_d[i] = per_out_i[sel_q[i]];
				poeb_d[i] = ~per_oe_i[sel_q[i]];
				pin_d[sel_q[i]] = filt_q[i];
			end
		end
		wake_d = |(ev[NPAD-1:0] & wken_q);
		irq_d = |(st_d & msk_q);
	end

	//*************************************************************************
	// Flip-flops
	//*************************************************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			dir_q <= DIR_RST;
			out_q <= '0;
			pu_q <= '0;
			pd_q <= '0;
			dben_q <= '0;
			wken_q <= '0;
			pol_q <= '0;
			st_q <= '0;
			msk_q <= '0;
			func_q <= FUNC_RST;
			sel_q <= '{default: SEL_NONE};
			cnt_q <= '{default: '0};
			filt_q <= '0;
			prev_q <= '0;
			rdata_o <= '0;
			pad_out_o <= '0;
			pad_oe_b_o <= '1;
			pad_pu_o <= '0;
			pad_pd_o <= '0;
			pad_ana_o <= '0;
			per_in_o <= '0;
			matrix_key_input_o <= '0;
			wake_o <= 1'b0;
			irq_o <= 1'b0;
		end else if (clk_en_i) begin
			dir_q <= dir_d;
			out_q <= out_d;
			pu_q <= pu_d;
			pd_q <= pd_d;
			dben_q <= dben_d;
			wken_q <= wken_d;
			pol_q <= pol_d;
			st_q <= st_d;
			msk_q <= msk_d;
			func_q <= func_d;
			sel_q <= sel_d;
			cnt_q <= cnt_d;
			filt_q <= filt_d;
			prev_q <= prev_d;
			rdata_o <= rdata_d;
			pad_out_o <= po_d;
			pad_oe_b_o <= poeb_d;
			pad_pu_o <= ppu_d;
			pad_pd_o <= ppd_d;
			pad_ana_o <= pana_d;
			per_in_o <= pin_d;
			matrix_key_input_o <= kin_d;
			wake_o <= wake_d;
			irq_o <= irq_d;
		end
	end
endmodule

// ===== test/padmux_properties.sv
// Port-timing checker for the pad router
`timescale 1ns/1ps
module padmux_chk (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [10:0] pad_oe_b_o,
	input wire logic [10:0] pad_pu_o,
	input wire logic wake_o,
	input wire logic irq_o
);
	import padmux_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic gpio_q;
	wire we = wr_i & clk_en_i;
	wire irqw = we && (addr_i == A_IRQST || addr_i == A_IRQMSK);
	//****
	// Mode shadow: tracks FUNC holding plain GPIO mode, where direction reaches every pad
	//****
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) gpio_q <= 1'b1;
		else if (we && addr_i == A_FUNC) gpio_q <= wdata_i[3:0] == FUNC_RST;
	end
	sequence cfg_wr(logic [7:0] a);
		we && addr_i == a;
	endsequence
	rd_idle_a: assert property (clk_en_i && !rd_i |=> rdata_o == 32'h0)
		else $error("rdata not zero");
	unmap_rd_a: assert property (clk_en_i && rd_i && addr_i == 8'hFC |=> rdata_o == 32'h0)
		else $error("unmapped read");
	rst_state_a: assert property ($rose(rst_b_i) |-> pad_oe_b_o == 11'h7FF && pad_pu_o == 11'h0)
		else $error("reset pads");
	dir_oe_a: assert property (cfg_wr(A_DIR) ##0 gpio_q |-> ##2 pad_oe_b_o == ~$past(wdata_i[10:0], 2))
		else $error("direction");
	pull_up_a: assert property (cfg_wr(A_PU) |-> ##2 pad_pu_o == $past(wdata_i[10:0], 2))
		else $error("pull-up");
	wake_pls_a: assert property (wake_o |=> !wake_o)
		else $error("wake pulse");
	irq_hold_a: assert property (irq_o && !irqw && !$past(irqw) |=> irq_o)
		else $error("irq dropped");
	msk_off_a: assert property (cfg_wr(A_IRQMSK) ##0 wdata_i[17:0] == 18'h0 |-> ##2 !irq_o)
		else $error("masked irq");
endmodule
bind padmux_top padmux_chk u_chk (.core_clk_i, .rst_b_i, .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .pad_oe_b_o, .pad_pu_o, .wake_o, .irq_o);

// ===== test/padmux_pad_model.sv
// Board side of the pads: drivers, pulls, floating lines
`timescale 1ns/1ps
module padmux_pad_model (
	input wire logic clk_i,
	input wire logic [10:0] out_i,
	input wire logic [10:0] oe_b_i,
	input wire logic [10:0] pu_i,
	input wire logic [10:0] pd_i,
	input wire logic [10:0] ext_i,
	input wire logic [10:0] ext_en_i,
	output logic [10:0] level_o
);
	logic [10:0] flt_q = 11'h0;
	// Open lines wander, so no stale level passes
	always @(posedge clk_i) flt_q <= ~flt_q;
	assign level_o = (~oe_b_i & out_i) | (oe_b_i & ext_en_i & ext_i)
		| (oe_b_i & ~ext_en_i & (pu_i | (~pd_i & flt_q)));
endmodule

// ===== test/tb.sv
// Bench for the pad router and general I/O port
`timescale 1ns/1ps
module tb;
	import padmux_pkg::*;
	logic core_clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, wake_o, irq_o;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0, rdata_o;
	logic [10:0] pad_in_i, pad_out_o, pad_oe_b_o, pad_pu_o, pad_pd_o, pad_ana_o;
	logic [10:0] dbg_oe_i = 11'h0, ext = 11'h0, ext_en = 11'h7FF;
	logic [10:0] dbg_out_i = 11'h0;
	logic clk_en_i = 1'b1;
	logic [18:0] per_out_i = 19'h0, per_oe_i = 19'h0, per_in_o;
	logic [17:0] matrix_key_output_i = 18'h0, matrix_key_input_o;
	int fails = 0, tests_run = 0;
	padmux_top u_padmux_top (.core_clk_i, .rst_b_i, .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.pad_in_i, .pad_out_o, .pad_oe_b_o, .pad_pu_o, .pad_pd_o, .pad_ana_o, .per_out_i, .per_oe_i, .per_in_o,
		.matrix_key_output_i, .matrix_key_input_o, .dbg_out_i, .dbg_oe_i, .wake_o, .irq_o);
	padmux_pad_model u_padmux_pad_model (.clk_i(core_clk_i), .out_i(pad_out_o), .oe_b_i(pad_oe_b_o),
		.pu_i(pad_pu_o), .pd_i(pad_pd_o), .ext_i(ext), .ext_en_i(ext_en), .level_o(pad_in_i));
	//****
	// Bus tasks
	//****
	task automatic tick(int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata", e, rdata_o & m);
	endtask
	task automatic t_gpio;
		rd(A_FUNC, 32'h2, 32'hF);
		wr(A_OUT, 32'h555);
		wr(A_DIR, 32'h0FF);
		ext <= 11'h500;
		tick(4);
		chk("oe", 11'h700, pad_oe_b_o);
		// Frozen clock enable must swallow the write
		clk_en_i <= 1'b0;
		wr(A_OUT, 32'h0AA);
		clk_en_i <= 1'b1;
		tick(2);
		chk("freeze", 11'h555, pad_out_o);
		wr(A_IN, 32'h0);
		rd(A_IN, 32'h555, 32'h7FF);
		rd(8'hFC, 32'h0, '1);
		wr(A_DIR, 32'h0);
		ext_en <= 11'h0;
		wr(A_PU, 32'h7FF);
		tick(4);
		rd(A_IN, 32'h7FF, 32'h7FF);
		wr(A_PU, 32'h0);
		wr(A_PD, 32'h7FF);
		tick(4);
		rd(A_IN, 32'h0, 32'h7FF);
		ext_en <= 11'h7FF;
		$display("gpio done");
	endtask
	task automatic t_irq;
		wr(A_IRQPOL, 32'h1);
		wr(A_WKEN, 32'h1);
		wr(A_IRQST, 32'h3FFFF);
		wr(A_IRQMSK, 32'h1);
		ext <= 11'h001;
		tick(2);
		chk("wake", 1, wake_o);
		tick(1);
		chk("wake pulse", 0, wake_o);
		chk("irq", 1, irq_o);
		rd(A_IRQST, 32'h1, 32'h1);
		wr(A_IRQMSK, 32'h0);
		tick(2);
		chk("irq masked", 0, irq_o);
		wr(A_IRQMSK, 32'h1);
		tick(2);
		chk("irq sticky", 1, irq_o);
		wr(A_IRQST, 32'h1);
		tick(2);
		chk("irq clear", 0, irq_o);
		// Steady level on pad 9 must be held back by the filter, then pass
		wr(A_DBEN, 32'h200);
		ext <= 11'h201;
		tick(8);
		rd(A_IN, 32'h0, 32'h200);
		tick(12);
		rd(A_IN, 32'h200, 32'h200);
		$display("irq done");
	endtask
	task automatic t_func;
		wr(A_FUNC, 32'h4);
		matrix_key_output_i <= 18'h2;
		tick(4);
		chk("key in", 1, matrix_key_input_o[8]);
		chk("key out", 1, {pad_oe_b_o[2], pad_out_o[2]});
		wr(A_FUNC, 32'h8);
		tick(2);
		chk("analog", ANA_PAD, pad_ana_o);
		wr(A_FUNC, 32'h0);
		wr(A_SEL0 + 8'h0C, 32'h5);
		per_out_i <= 19'h20;
		per_oe_i <= 19'h20;
		tick(4);
		chk("map", 1, {pad_oe_b_o[3], pad_out_o[3]});
		chk("map in", 1, per_in_o[5]);
		wr(A_FUNC, 32'h1);
		dbg_oe_i <= 11'h018;
		dbg_out_i <= 11'h010;
		tick(4);
		chk("debug", 0, {pad_oe_b_o[3], pad_out_o[3]});
		chk("debug out", 1, {pad_oe_b_o[4], pad_out_o[4]});
		$display("func done");
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		forever #2 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (20) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		tick(1);
		chk("reset oe", 11'h7FF, pad_oe_b_o);
		t_gpio;
		t_irq;
		t_func;
		test_done;
	end
	// Whole run needs about 140 cycles
	initial begin
		repeat (3000) @(posedge core_clk_i);
		fails++;
		test_done;
	end
endmodule
